// File: hdl/spi_port_pkg.sv
package spi_port_pkg;

	// ----------------------------------------------------------------
	// frame shape
	// ----------------------------------------------------------------
	localparam int         DATA_BITS = 8;
	localparam logic [3:0] LAST_EDGE = 4'hf;  // sixteen clock transitions per byte

	// ----------------------------------------------------------------
	// register indices on the cpu port
	// ----------------------------------------------------------------
	localparam logic [1:0] IDX_DATA = 2'h0;
	localparam logic [1:0] IDX_CTRL = 2'h1;
	localparam logic [1:0] IDX_STAT = 2'h2;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTL_IRQ_EN   = 7;
	localparam int CTL_PORT_EN  = 6;
	localparam int CTL_MASTER   = 5;
	localparam int CTL_CLOCK_POLARITY_BIT     = 4;
	localparam int CTL_CLOCK_PHASE_BIT     = 3;
	localparam int CTL_RATE_MSB = 2;
	localparam int ST_DONE      = 7;
	localparam int ST_WRITE_COLLISION_FLAG      = 6;
	localparam int ST_OVR       = 5;
	localparam int ST_MODE_FAULT_FLAG      = 4;
	localparam int ST_SOFT_EN   = 1;
	localparam int ST_SOFT_LVL  = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// ----------------------------------------------------------------
	// half periods of the master clock, in cpu clocks
	// ----------------------------------------------------------------
	localparam logic [6:0] HALF_DIV4   = 7'h02;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV16  = 7'h08;
	localparam logic [6:0] HALF_DIV32  = 7'h10;
	localparam logic [6:0] HALF_DIV64  = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;

	typedef enum logic [0:0] {
		XFER_IDLE  = 1'b0,
		XFER_SHIFT = 1'b1
	} xfer_t;

	// rate code to half period; bit 2 set halves codes 000 and 010, and quarters codes 001 and 011
	function automatic logic [6:0] half_period(input logic [2:0] rate);
		case (rate)
			3'b100, 3'b101: half_period = HALF_DIV4;
			3'b000:         half_period = HALF_DIV8;
			3'b001:         half_period = HALF_DIV16;
			3'b110, 3'b111: half_period = HALF_DIV32;
			3'b010:         half_period = HALF_DIV64;
			default:        half_period = HALF_DIV128;
		endcase
	endfunction

	// odd transitions sample when phase is 1, even ones when phase is 0
	function automatic logic is_sample_edge(input logic idx_lsb, input logic clock_phase_bit);
		is_sample_edge = (idx_lsb == clock_phase_bit);
	endfunction

endpackage

// File: hdl/spi_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
	logic dev_sck_o;
	logic dev_sck_oe;
	logic dev_mosi_o;
	logic dev_mosi_oe;
	logic dev_miso_o;
	logic dev_miso_oe;
	logic peer_sck_o;
	logic peer_mosi_o;
	logic peer_mosi_oe;
	logic peer_miso_o;
	logic peer_miso_oe;
	logic peer_ss_n_o;
	logic sck;
	logic mosi;
	logic miso;
	logic ss_n;

	// ----------------------------------------------------------------
	// wire levels; the peer clock level doubles as the idle pull
	// ----------------------------------------------------------------
	assign sck  = dev_sck_oe ? dev_sck_o : peer_sck_o;
	assign mosi = dev_mosi_oe ? dev_mosi_o : (peer_mosi_oe ? peer_mosi_o : 1'b1);
	assign miso = dev_miso_oe ? dev_miso_o : (peer_miso_oe ? peer_miso_o : 1'b1);
	assign ss_n = peer_ss_n_o;

	modport dev_end (
		output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
		input  sck, mosi, miso, ss_n
	);
	modport peer_end (
		output peer_sck_o, peer_mosi_o, peer_mosi_oe, peer_miso_o, peer_miso_oe, peer_ss_n_o,
		input  sck, mosi, miso
	);
endinterface

`default_nettype wire

// File: hdl/spi_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module spi_pin_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic [W-1:0] pin_d,
	output logic      [W-1:0] pin_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t s_reg;
	sync_t s_next;

	// two stages; only the second stage is visible to the caller
	always_comb begin
		s_next    = s_reg;
		s_next.s1 = pin_d;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_q = s_reg.s2;
endmodule

`default_nettype wire

// File: hdl/spi_port_dev.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - soft select replaces pin with select level
// - master keeps internal select level high
// - phase one slave: select low whole transfer
// - phase zero: select per byte, else collision
// - master drives clock at configured rate
// - configure rate, select, then master enable
// - master and enable survive only select high
// - data write loads shifter, msb first
// - byte end sets done, optional interrupt
// - done clears: status access then data read, or data write as slave
// - data writes ignored while done unseen
// - slave starts on incoming master clock
// - polarity and phase pick edges, idle
// - disable port before changing polarity
// - select low as master: fault, drop
// - fault clears: status read, control write
// - fault blocks setting enable or master
// - slave never raises mode fault
// - completion over unread byte sets overrun
// - status read clears overrun
// - write during transfer collides, no irq
// - data write never clears collision
// - three rate bits, six dividers, master
module spi_port_dev (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic [1:0] cpu_idx,
	input  wire logic       cpu_wr,
	input  wire logic       cpu_rd,
	input  wire logic [7:0] cpu_wdata,
	input  wire logic       cpu_irq_mask,
	output logic      [7:0] cpu_rdata,
	output logic            irq_req,
	spi_link_if.dev_end     link
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		spi_port_pkg::xfer_t st;
		logic [3:0]          idx;
		logic [6:0]          div;
		logic                sck;
		logic                sck_prev;
		logic                dout;
		logic [7:0]          shift;
		logic [7:0]          rxbuf;
		logic                irq_en;
		logic                port_en;
		logic                master;
		logic                clock_polarity_bit;
		logic                clock_phase_bit;
		logic [2:0]          rate;
		logic                soft_en;
		logic                soft_lvl;
		logic                done;
		logic                write_collision_flag;
		logic                overrun_flag;
		logic                mode_fault_flag;
		logic                seen_done;
		logic                seen_write_collision_flag;
		logic                seen_mode_fault_flag;
		logic [7:0]          rdata;
		logic                irq;
		logic                sck_oe;
		logic                mosi_oe;
		logic                miso_oe;
	} dev_state_t;

	dev_state_t s_reg;
	dev_state_t s_next;
	logic [3:0] pin_q;  // {ss_n, miso, mosi, sck}

	spi_pin_sync #(
		.W(4)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.pin_d  ({link.ss_n, link.miso, link.mosi, link.sck}),
		.pin_q  (pin_q)
	);

	// ----------------------------------------------------------------
	// next state: cpu accesses first, hardware events after so sets win
	// ----------------------------------------------------------------
	always_comb begin
		logic       ss_int;
		logic       edge_ev;
		logic       din;
		logic       busy;
		logic       fault_ok;
		logic [7:0] nshift;
		s_next   = s_reg;
		ss_int   = s_reg.soft_en ? s_reg.soft_lvl : pin_q[3];
		edge_ev  = 1'b0;
		din      = s_reg.master ? pin_q[2] : pin_q[1];
		nshift   = {s_reg.shift[6:0], din};
		fault_ok = !s_reg.mode_fault_flag || s_reg.seen_mode_fault_flag;
		// a phase-zero slave left selected counts as mid-transfer
		busy = (s_reg.st == spi_port_pkg::XFER_SHIFT) ||
			(!s_reg.master && s_reg.port_en && !s_reg.clock_phase_bit && !ss_int);

		// register writes
		if (cpu_wr) begin
			case (cpu_idx)
				spi_port_pkg::IDX_CTRL: begin
					s_next.irq_en  = cpu_wdata[spi_port_pkg::CTL_IRQ_EN];
					s_next.port_en = cpu_wdata[spi_port_pkg::CTL_PORT_EN] && fault_ok;
					s_next.master  = cpu_wdata[spi_port_pkg::CTL_MASTER] && fault_ok;
					s_next.clock_polarity_bit    = cpu_wdata[spi_port_pkg::CTL_CLOCK_POLARITY_BIT];
					s_next.clock_phase_bit    = cpu_wdata[spi_port_pkg::CTL_CLOCK_PHASE_BIT];
					s_next.rate    = cpu_wdata[spi_port_pkg::CTL_RATE_MSB:0];
					if (s_reg.seen_mode_fault_flag) begin
						s_next.mode_fault_flag      = 1'b0;
						s_next.seen_mode_fault_flag = 1'b0;
					end
				end
				spi_port_pkg::IDX_STAT: begin
					s_next.soft_en   = cpu_wdata[spi_port_pkg::ST_SOFT_EN];
					s_next.soft_lvl  = cpu_wdata[spi_port_pkg::ST_SOFT_LVL];
					s_next.seen_done = s_reg.done;
				end
				spi_port_pkg::IDX_DATA: begin
					if (s_reg.done && !s_reg.seen_done) begin
						s_next.write_collision_flag = s_reg.write_collision_flag;
					end else if (busy) begin
						s_next.write_collision_flag = 1'b1;
					end else begin
						s_next.shift = cpu_wdata;
						s_next.dout  = cpu_wdata[7];
						if (s_reg.master && s_reg.port_en) begin
							s_next.st  = spi_port_pkg::XFER_SHIFT;
							s_next.idx = 4'h0;
							s_next.div = spi_port_pkg::half_period(s_reg.rate);
						end
					end
					// a slave may also finish the done sequence with a write
					if (!s_reg.master && s_reg.seen_done) begin
						s_next.done      = 1'b0;
						s_next.seen_done = 1'b0;
					end
				end
				default: s_next.rdata = s_reg.rdata;
			endcase
		end

		// register reads, answered on the following edge
		if (cpu_rd) begin
			case (cpu_idx)
				spi_port_pkg::IDX_DATA: begin
					s_next.rdata = s_reg.rxbuf;
					if (s_reg.seen_done) begin
						s_next.done      = 1'b0;
						s_next.seen_done = 1'b0;
					end
					if (s_reg.seen_write_collision_flag) begin
						s_next.write_collision_flag      = 1'b0;
						s_next.seen_write_collision_flag = 1'b0;
					end
				end
				spi_port_pkg::IDX_CTRL: begin
					s_next.rdata = {s_reg.irq_en, s_reg.port_en, s_reg.master,
						s_reg.clock_polarity_bit, s_reg.clock_phase_bit, s_reg.rate};
				end
				spi_port_pkg::IDX_STAT: begin
					s_next.rdata = {s_reg.done, s_reg.write_collision_flag, s_reg.overrun_flag, s_reg.mode_fault_flag,
						2'b00, s_reg.soft_en, s_reg.soft_lvl};
					s_next.overrun_flag       = 1'b0;
					s_next.seen_done = s_reg.done;
					s_next.seen_write_collision_flag = s_reg.write_collision_flag;
					s_next.seen_mode_fault_flag = s_reg.mode_fault_flag;
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end

		// ----------------------------------------------------------------
		// clock generation (master) or clock edge detection (slave)
		// ----------------------------------------------------------------
		s_next.sck_prev = pin_q[0];
		// a non-master parks its clock at the idle level, so taking mastership makes no edge
		s_next.sck      = s_reg.master ? s_reg.sck : s_next.clock_polarity_bit;
		if (s_reg.master) begin
			if (s_reg.st == spi_port_pkg::XFER_SHIFT) begin
				if (s_reg.div == 7'h01) begin
					s_next.div = spi_port_pkg::half_period(s_reg.rate);
					s_next.sck = !s_reg.sck;
					edge_ev    = 1'b1;
				end else begin
					s_next.div = s_reg.div - 7'h01;
				end
			end else begin
				s_next.sck = s_reg.clock_polarity_bit;
			end
		end else if (s_reg.port_en && !ss_int) begin
			edge_ev = (pin_q[0] != s_reg.sck_prev);
		end else if (!s_reg.master) begin
			// deselected slave drops any partial byte and presents its msb
			s_next.idx  = 4'h0;
			s_next.st   = spi_port_pkg::XFER_IDLE;
			s_next.dout = s_reg.shift[7];
		end

		// ----------------------------------------------------------------
		// shifting: sample edges shift in, the others present the next bit
		// ----------------------------------------------------------------
		if (edge_ev) begin
			s_next.st  = spi_port_pkg::XFER_SHIFT;
			s_next.idx = s_reg.idx + 4'h1;
			if (spi_port_pkg::is_sample_edge(s_reg.idx[0], s_reg.clock_phase_bit)) begin
				s_next.shift = nshift;
			end else begin
				s_next.dout = s_reg.shift[7];
			end
			if (s_reg.idx == spi_port_pkg::LAST_EDGE) begin
				s_next.st  = spi_port_pkg::XFER_IDLE;
				s_next.idx = 4'h0;
				if (s_next.done) begin
					s_next.overrun_flag = 1'b1;
				end else begin
					s_next.done  = 1'b1;
					s_next.rxbuf = s_reg.clock_phase_bit ? nshift : s_reg.shift;
				end
			end
		end

		if (!s_next.port_en) begin
			s_next.st  = spi_port_pkg::XFER_IDLE;
			s_next.idx = 4'h0;
		end

		// mode fault takes priority over any control write this cycle
		if (s_reg.master && !ss_int) begin
			s_next.mode_fault_flag    = 1'b1;
			s_next.port_en = 1'b0;
			s_next.master  = 1'b0;
			s_next.st      = spi_port_pkg::XFER_IDLE;
			s_next.idx     = 4'h0;
			s_next.sck     = s_reg.clock_polarity_bit;
		end

		// pin enables; a slave drives its output only while selected
		s_next.sck_oe  = s_next.port_en && s_next.master;
		s_next.mosi_oe = s_next.port_en && s_next.master;
		s_next.miso_oe = s_next.port_en && !s_next.master && !ss_int;
		// no collision term: that flag is status only
		s_next.irq = s_next.irq_en && !cpu_irq_mask &&
			(s_next.done || s_next.mode_fault_flag || s_next.overrun_flag);
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign cpu_rdata        = s_reg.rdata;
	assign irq_req          = s_reg.irq;
	assign link.dev_sck_o   = s_reg.sck;
	assign link.dev_sck_oe  = s_reg.sck_oe;
	assign link.dev_mosi_o  = s_reg.dout;
	assign link.dev_mosi_oe = s_reg.mosi_oe;
	assign link.dev_miso_o  = s_reg.dout;
	assign link.dev_miso_oe = s_reg.miso_oe;
endmodule

`default_nettype wire

// File: hdl/spi_peer_end.sv
`timescale 1ns/1ps
`default_nettype none

module spi_peer_end (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       role_master,
	input  wire logic       clock_polarity_bit,
	input  wire logic       clock_phase_bit,
	input  wire logic       hold_select,
	input  wire logic [7:0] half_period,
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	output logic            busy,
	output logic      [7:0] rx_byte,
	output logic            rx_valid,
	spi_link_if.peer_end    link
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		spi_port_pkg::xfer_t st;
		logic [3:0]          idx;
		logic [7:0]          div;
		logic                sck;
		logic                sck_prev;
		logic                dout;
		logic                ss_n;
		logic [7:0]          shift;
		logic [7:0]          rx;
		logic                rx_valid;
		logic                busy;
	} peer_state_t;

	peer_state_t s_reg;
	peer_state_t s_next;
	logic [2:0]  pin_q;  // {miso, mosi, sck}

	spi_pin_sync #(
		.W(3)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.pin_d  ({link.miso, link.mosi, link.sck}),
		.pin_q  (pin_q)
	);

	// ----------------------------------------------------------------
	// one engine for both roles; half_period of zero is treated as one
	// ----------------------------------------------------------------
	always_comb begin
		logic       edge_ev;
		logic       din;
		logic [7:0] nshift;
		s_next          = s_reg;
		edge_ev         = 1'b0;
		din             = role_master ? pin_q[2] : pin_q[1];
		nshift          = {s_reg.shift[6:0], din};
		s_next.rx_valid = 1'b0;
		s_next.sck_prev = pin_q[0];

		if (start && !s_reg.busy) begin
			s_next.shift = tx_byte;
			s_next.dout  = tx_byte[7];
			s_next.busy  = 1'b1;
			s_next.idx   = 4'h0;
			s_next.div   = half_period;
			if (role_master) begin
				s_next.st   = spi_port_pkg::XFER_SHIFT;
				s_next.ss_n = 1'b0;
			end
		end

		if (role_master) begin
			if (s_reg.st == spi_port_pkg::XFER_SHIFT) begin
				if (s_reg.div <= 8'h01) begin
					s_next.div = half_period;
					s_next.sck = !s_reg.sck;
					edge_ev    = 1'b1;
				end else begin
					s_next.div = s_reg.div - 8'h01;
				end
			end else begin
				s_next.sck = clock_polarity_bit;
			end
		end else begin
			// never select a device that is acting as master
			s_next.ss_n = 1'b1;
			s_next.sck  = clock_polarity_bit;
			edge_ev     = (pin_q[0] != s_reg.sck_prev);
		end

		if (edge_ev) begin
			s_next.st  = spi_port_pkg::XFER_SHIFT;
			s_next.idx = s_reg.idx + 4'h1;
			if (spi_port_pkg::is_sample_edge(s_reg.idx[0], clock_phase_bit)) begin
				s_next.shift = nshift;
			end else begin
				s_next.dout = s_reg.shift[7];
			end
			if (s_reg.idx == spi_port_pkg::LAST_EDGE) begin
				s_next.st       = spi_port_pkg::XFER_IDLE;
				s_next.idx      = 4'h0;
				s_next.busy     = 1'b0;
				s_next.rx       = clock_phase_bit ? nshift : s_reg.shift;
				s_next.rx_valid = 1'b1;
				// phase zero needs a high gap between bytes
				s_next.ss_n     = role_master ? !hold_select : 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign busy              = s_reg.busy;
	assign rx_byte           = s_reg.rx;
	assign rx_valid          = s_reg.rx_valid;
	assign link.peer_sck_o   = s_reg.sck;
	assign link.peer_mosi_o  = s_reg.dout;
	assign link.peer_mosi_oe = role_master;
	assign link.peer_miso_o  = s_reg.dout;
	assign link.peer_miso_oe = !role_master;
	assign link.peer_ss_n_o  = s_reg.ss_n;
endmodule

`default_nettype wire

// File: verification/spi_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module spi_link_monitor (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic dev_sck_oe,
	input wire logic dev_mosi_oe,
	input wire logic dev_miso_oe,
	input wire logic peer_mosi_oe,
	input wire logic peer_miso_oe,
	input wire logic sck,
	input wire logic ss_n
);
	// ----------------------------------------------------------------
	// link checks, one clock domain
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// who drives what: a master owns clock and mosi, a slave only miso
	chk_master_owns_clk: assert property (dev_sck_oe |-> dev_mosi_oe && !dev_miso_oe)
		else $error("device clock driven without mosi or with miso");
	chk_slave_miso_only: assert property (dev_miso_oe |-> !dev_mosi_oe && !dev_sck_oe)
		else $error("device miso driven beside master outputs");
	chk_mosi_one_driver: assert property (!(dev_mosi_oe && peer_mosi_oe))
		else $error("both ends drive mosi");
	chk_miso_one_driver: assert property (!(dev_miso_oe && peer_miso_oe))
		else $error("both ends drive miso");

	// clock only moves inside frames; the guard skips the reset fallout
	chk_idle_sck_still: assert property ($past(resetn, 2) && !dev_sck_oe && !peer_mosi_oe |-> $stable(sck))
		else $error("serial clock moved with no master on the link");
	chk_peer_clk_framed: assert property ($past(resetn) && peer_mosi_oe && $changed(sck) |-> !ss_n)
		else $error("peer clocked the link with select high");

	// fastest rate is a quarter of the cpu clock: two cycles per level
	chk_sck_half_min: assert property (dev_sck_oe && $past(dev_sck_oe) && $changed(sck) |=> $stable(sck))
		else $error("device clock level shorter than two cycles");
	chk_reset_release: assert property ($rose(resetn) |-> !dev_sck_oe && !dev_mosi_oe && !dev_miso_oe)
		else $error("device outputs enabled straight out of reset");

	cov_dev_clocks: cover property (dev_sck_oe && $changed(sck));
	cov_peer_clocks: cover property (peer_mosi_oe && $changed(sck));
	cov_dev_slave_out: cover property (dev_miso_oe && $changed(sck));
endmodule

`default_nettype wire

// File: verification/spi_master_slave_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_port_tb;
	typedef struct packed {
		logic       clock_polarity_bit;
		logic       clock_phase_bit;
		logic [2:0] rate;
		logic [7:0] half;
		logic [7:0] db;
		logic [7:0] pb;
	} row_t;
	localparam logic [1:0] DI = spi_port_pkg::IDX_DATA;
	localparam logic [1:0] CI = spi_port_pkg::IDX_CTRL;
	localparam logic [1:0] SI = spi_port_pkg::IDX_STAT;
	logic       clk_sys      = 1'b0;
	logic       resetn       = 1'b0;
	logic [1:0] cpu_idx      = 2'h0;
	logic [7:0] cpu_wdata    = 8'h00;
	logic [1:0] cpu_wr       = 2'h0;
	logic [1:0] cpu_rd       = 2'h0;
	logic       cpu_irq_mask = 1'b0;
	logic       role_master  = 1'b0;
	logic       clock_polarity_bit         = 1'b0;
	logic       clock_phase_bit         = 1'b0;
	logic       hold_select  = 1'b0;
	logic [7:0] half_period  = 8'h08;  // a slave answer needs six cycles to come back
	logic       start        = 1'b0;
	logic [7:0] tx_byte      = 8'h00;
	logic       ss_f         = 1'b1;
	logic       sck_q        = 1'b0;
	wire  [7:0] rdata [2];
	wire  [1:0] irq;
	logic [7:0] rx_byte;
	logic       rx_valid;
	int         fail_count   = 0;
	int         n_compared   = 0;
	int         cycles       = 0;
	int         sck_edges    = 0;
	int         e_mark       = 0;
	int         h            = 0;
	int         i            = 0;
	// rows: polarity, phase, rate code, half period in cycles, device byte, peer byte
	row_t rows [4] = '{
		'{1'b0, 1'b0, 3'b001, 8'h08, 8'ha5, 8'h3c},
		'{1'b0, 1'b1, 3'b110, 8'h10, 8'h81, 8'h7e},
		'{1'b1, 1'b0, 3'b010, 8'h20, 8'h01, 8'hc4},
		'{1'b1, 1'b1, 3'b011, 8'h40, 8'hf0, 8'h5b}
	};

	// ----------------------------------------------------------------
	// two ends on one link, a lone device on a link the bench abuses
	// ----------------------------------------------------------------
	spi_link_if link ();
	spi_link_if link_f ();
	spi_port_dev spi_port_dev_i (.clk_sys(clk_sys), .resetn(resetn), .cpu_idx(cpu_idx),
		.cpu_wr(cpu_wr[0]), .cpu_rd(cpu_rd[0]), .cpu_wdata(cpu_wdata),
		.cpu_irq_mask(cpu_irq_mask), .cpu_rdata(rdata[0]), .irq_req(irq[0]), .link(link));
	spi_port_dev spi_port_dev_fault_i (.clk_sys(clk_sys), .resetn(resetn), .cpu_idx(cpu_idx),
		.cpu_wr(cpu_wr[1]), .cpu_rd(cpu_rd[1]), .cpu_wdata(cpu_wdata),
		.cpu_irq_mask(cpu_irq_mask), .cpu_rdata(rdata[1]), .irq_req(irq[1]), .link(link_f));
	spi_peer_end spi_peer_end_i (.clk_sys(clk_sys), .resetn(resetn), .role_master(role_master),
		.clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .hold_select(hold_select), .half_period(half_period),
		.start(start), .tx_byte(tx_byte), .busy(), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.link(link));
	spi_link_monitor spi_link_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
		.dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
		.dev_miso_oe(link.dev_miso_oe), .peer_mosi_oe(link.peer_mosi_oe),
		.peer_miso_oe(link.peer_miso_oe), .sck(link.sck), .ss_n(link.ss_n));

	// fault link: clock pulled low, data released, select under bench control
	assign {link_f.peer_sck_o, link_f.peer_mosi_o, link_f.peer_mosi_oe} = 3'h0;
	assign {link_f.peer_miso_o, link_f.peer_miso_oe} = 2'h0;
	assign link_f.peer_ss_n_o = ss_f;

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// clock transitions on the main link, and the hang limit
	always @(posedge clk_sys) begin
		if (link.sck !== sck_q) begin
			sck_edges++;
		end
		sck_q = link.sck;
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done;
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task rst;
		resetn = 1'b0;
		repeat (3) @(negedge clk_sys);
		resetn = 1'b1;
	endtask

	task wr(input int s, input logic [1:0] idx, input logic [7:0] d);
		@(negedge clk_sys);
		cpu_idx = idx;
		cpu_wdata = d;
		cpu_wr[s] = 1'b1;
		@(negedge clk_sys);
		cpu_wr[s] = 1'b0;
	endtask

	// one extra cycle so the registered read data has surely landed
	task rd(input int s, input logic [1:0] idx, input logic [7:0] exp);
		@(negedge clk_sys);
		cpu_idx = idx;
		cpu_rd[s] = 1'b1;
		@(negedge clk_sys);
		cpu_rd[s] = 1'b0;
		@(negedge clk_sys);
		chk(rdata[s], exp);
	endtask

	task pstart(input logic [7:0] pb);
		@(negedge clk_sys);
		tx_byte = pb;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
	endtask

	task xfer(input logic [7:0] pb, input logic [7:0] db);
		pstart(pb);
		e_mark = sck_edges;
		wr(0, DI, db);
	endtask

	// 0: device interrupt, 1: peer byte end, 2: sixteen transitions since the mark
	task wait_for(input int w);
		int k;
		for (k = 0; k < 3000; k++) begin
			@(negedge clk_sys);
			if (w == 0 && irq[0] === 1'b1) break;
			if (w == 1 && rx_valid === 1'b1) break;
			if (w == 2 && sck_edges - e_mark >= 16) break;
		end
		chk({7'h0, k < 3000}, 8'h01);
	endtask

	// cycles between the first two clock transitions of a byte
	task half_meas;
		int e;
		e = sck_edges;
		for (h = 0; h < 300 && sck_edges == e; h++) @(negedge clk_sys);
		e = sck_edges;
		for (h = 0; h < 300 && sck_edges == e; h++) @(negedge clk_sys);
	endtask

	task test_done;
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		rst;
		// reset values, the unmapped slot reads zero, and a write to it leaves control clear
		for (i = 0; i < 4; i++) rd(0, i[1:0], 8'h00);
		wr(0, 2'h3, 8'hff);
		rd(0, CI, 8'h00);
		// device master, peer slave, one byte per timing mode
		for (i = 0; i < 4; i++) begin
			clock_polarity_bit = rows[i].clock_polarity_bit;
			clock_phase_bit = rows[i].clock_phase_bit;
			rst;
			wr(0, CI, {3'b000, clock_polarity_bit, clock_phase_bit, rows[i].rate});
			wr(0, SI, 8'h03);
			wr(0, CI, {3'b111, clock_polarity_bit, clock_phase_bit, rows[i].rate});
			rd(0, CI, {3'b111, clock_polarity_bit, clock_phase_bit, rows[i].rate});
			xfer(rows[i].pb, rows[i].db);
			half_meas;
			chk(h[7:0], rows[i].half);
			wait_for(0);
			wait_for(1);
			chk(8'(sck_edges - e_mark), 8'h10);
			chk(rx_byte, rows[i].db);
			rd(0, SI, 8'h83);
			rd(0, DI, rows[i].pb);
			rd(0, SI, 8'h03);
			chk({7'h0, irq[0]}, 8'h00);
		end
		// a write mid-byte collides; a write over an unseen flag is dropped
		xfer(8'h0f, 8'hc3);
		wr(0, DI, 8'h99);
		wait_for(0);
		wait_for(1);
		chk(rx_byte, 8'hc3);
		e_mark = sck_edges;
		wr(0, DI, 8'h5a);
		repeat (80) @(negedge clk_sys);
		chk(8'(sck_edges - e_mark), 8'h00);
		rd(0, SI, 8'hc3);
		rd(0, DI, 8'h0f);
		rd(0, SI, 8'h03);
		// second byte over an unread first one, with the cpu mask up
		xfer(8'h11, 8'h22);
		wait_for(0);
		rd(0, SI, 8'h83);
		cpu_irq_mask = 1'b1;
		xfer(8'h44, 8'h55);
		wait_for(2);
		repeat (4) @(negedge clk_sys);
		chk({7'h0, irq[0]}, 8'h00);
		cpu_irq_mask = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({7'h0, irq[0]}, 8'h01);
		chk(rx_byte, 8'h55);
		rd(0, SI, 8'ha3);
		rd(0, DI, 8'h11);
		rd(0, SI, 8'h03);
		// device slave at the link rate; select stays low between bytes
		role_master = 1'b1;
		hold_select = 1'b1;
		clock_polarity_bit = 1'b0;
		for (i = 0; i < 2; i++) begin
			clock_phase_bit = (i == 0);
			rst;
			wr(0, CI, {4'b1100, clock_phase_bit, 3'b000});
			if (clock_phase_bit) wr(0, DI, 8'h6e);
			pstart(8'hb7);
			wait_for(1);
			if (clock_phase_bit) chk(rx_byte, 8'h6e);
			wait_for(0);
			rd(0, SI, 8'h80);
			wr(0, DI, 8'h7d);
			rd(0, SI, clock_phase_bit ? 8'h00 : 8'h40);
			rd(0, DI, 8'hb7);
		end
		// lone device: select pulled low under a master, then under a slave
		rst;
		wr(1, CI, 8'he1);
		rd(1, CI, 8'he1);
		ss_f = 1'b0;
		repeat (4) @(negedge clk_sys);
		ss_f = 1'b1;
		rd(1, CI, 8'h81);
		chk({7'h0, link_f.dev_sck_oe}, 8'h00);
		chk({7'h0, irq[1]}, 8'h01);
		wr(1, CI, 8'he1);
		rd(1, CI, 8'h81);
		rd(1, SI, 8'h10);
		wr(1, CI, 8'he1);
		rd(1, SI, 8'h00);
		rd(1, CI, 8'he1);
		wr(1, SI, 8'h03);
		ss_f = 1'b0;
		repeat (4) @(negedge clk_sys);
		rd(1, CI, 8'he1);
		ss_f = 1'b1;
		rd(1, SI, 8'h03);
		wr(1, SI, 8'h00);
		wr(1, CI, 8'h41);
		ss_f = 1'b0;
		repeat (4) @(negedge clk_sys);
		ss_f = 1'b1;
		rd(1, SI, 8'h00);
		test_done;
	end
endmodule

`default_nettype wire
